// ---- design/vpic_pkg.sv ----
`default_nettype none
package vpic_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] REQ0_ADDR  = 12'hFC0;
    localparam logic [11:0] EN0H_ADDR  = 12'hFC1;
    localparam logic [11:0] EN0L_ADDR  = 12'hFC2;
    localparam logic [11:0] REQ1_ADDR  = 12'hFC3;
    localparam logic [11:0] EN1H_ADDR  = 12'hFC4;
    localparam logic [11:0] EN1L_ADDR  = 12'hFC5;
    localparam logic [11:0] REQ2_ADDR  = 12'hFC6;
    localparam logic [11:0] EN2H_ADDR  = 12'hFC7;
    localparam logic [11:0] EN2L_ADDR  = 12'hFC8;
    localparam logic [11:0] CTRL_ADDR  = 12'hFCF;
    localparam int          CTRL_IEN_BIT = 7;
    localparam logic [7:0]  REQ_RESET  = 8'h00;
    localparam logic [7:0]  REQ0_MASK  = 8'h7F;
    localparam logic [7:0]  REQ2_MASK  = 8'h0F;

    // ****************************************************************
    // Sources and vectors
    // ****************************************************************
    localparam int          NUM_SRC    = 19;
    localparam int          NUM_PERIPH = 7;
    localparam int          NUM_PORTA  = 8;
    localparam logic [15:0] VEC_WDOG   = 16'h0004;
    localparam logic [15:0] VEC_PERIPH = 16'h000A;
    localparam logic [15:0] VEC_PORTA  = 16'h0018;
    localparam logic [15:0] VEC_PORTC  = 16'h0030;
    localparam logic [15:0] VEC_STEP   = 16'h0002;

    // Priority encoding from high and low enable bits
    typedef enum logic [1:0] {
        VPIC_OFF = 2'b00,
        VPIC_LV1 = 2'b01,
        VPIC_LV2 = 2'b10,
        VPIC_LV3 = 2'b11
    } vpic_level_e;

    // Core side instruction events
    typedef struct packed {
        logic enableInstr;
        logic disableInstr;
        logic returnInstr;
        logic trapInstr;
        logic illegalTrap;
    } vpic_core_ev_s;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } vpic_bus_s;
endpackage
`default_nettype wire

// ---- design/vpic_controller.sv ----
// Behaviour
// - Nineteen vectors: twelve pin, seven peripheral
// - Vector words: high byte even address
// - Peripheral vectors 000A..0016 fixed order
// - Port A pins vectors 0018..0026
// - Port C pins from 0030, lowest
// - Watchdog vector 0004 outside table
// - Enable set by instruction, return, write
// - Enable cleared by disable, ack, traps
// - Level three beats two beats one
// - Same level: lowest vector wins
// - Watchdog and traps override programmable sources
// - Acknowledge clears matching request bit
// - Writing zero clears a request
// - Writing one creates a request
// - Source pulse always sets its bit
// - Forward only with global enable
// - Polling depends on request bits only
// - Watchdog ignores request and enable registers
// - First request register layout, reset zero
// - Two enable bits encode priority
//
// Chosen here: strobed register access.
`default_nettype none
module vpic_controller
    import vpic_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // Register port
    input  wire vpic_pkg::vpic_bus_s  bus,
    output var  logic [7:0]           rdata,
    // Interrupt sources
    input  wire logic [6:0]           periphPulse,
    input  wire logic [7:0]           portAPulse,
    input  wire logic [3:0]           portCPulse,
    input  wire logic                 watchdogPulse,
    input  wire logic                 watchdogEnable,
    // Core side
    input  wire vpic_pkg::vpic_core_ev_s coreEv,
    input  wire logic                 ackValid,
    input  wire logic [4:0]           ackSource,
    input  wire logic                 watchdogAck,
    output var  logic                 irqValid,
    output var  logic [15:0]          irqVector,
    output var  logic [4:0]           irqSource
);
    import vpic_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NUM_SRC-1:0] req;
        logic [NUM_SRC-1:0] enHigh;
        logic [NUM_SRC-1:0] enLow;
        logic               ien;
        logic               wdogPend;
        logic [7:0]         rdata;
        logic               irqValid;
        logic [15:0]        irqVector;
        logic [4:0]         irqSource;
    } vpic_state_s;

    vpic_state_s st;
    vpic_state_s next_st;

    // Source index order equals vector order: 0..6 peripherals, 7..14 port A, 15..18 port C
    function automatic logic [15:0] vecOf(input logic [4:0] idx);
        if (idx < 5'(NUM_PERIPH))
            vecOf = VEC_PERIPH + 16'(VEC_STEP * idx);
        else if (idx < 5'(NUM_PERIPH + NUM_PORTA))
            vecOf = VEC_PORTA + 16'(VEC_STEP * (idx - 5'(NUM_PERIPH)));
        else
            vecOf = VEC_PORTC + 16'(VEC_STEP * (idx - 5'(NUM_PERIPH + NUM_PORTA)));
    endfunction

    // Register byte to source bits: peripheral bit 6 is timer one, index 0
    function automatic logic [6:0] revPeriph(input logic [6:0] b);
        for (int i = 0; i < 7; i++)
            revPeriph[i] = b[6 - i];
    endfunction

    function automatic logic [7:0] revByte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            revByte[i] = b[7 - i];
    endfunction

    function automatic logic [3:0] revNib(input logic [3:0] b);
        for (int i = 0; i < 4; i++)
            revNib[i] = b[3 - i];
    endfunction

    // Map a register byte to the 19 source positions
    function automatic logic [NUM_SRC-1:0] toSrc(input logic [1:0] grp, input logic [7:0] d);
        toSrc = '0;
        case (grp)
            2'd0:    toSrc[6:0]   = revPeriph(d[6:0]);
            2'd1:    toSrc[14:7]  = revByte(d);
            2'd2:    toSrc[18:15] = revNib(d[3:0]);
            default: toSrc = '0;
        endcase
    endfunction

    function automatic logic [7:0] fromSrc(input logic [1:0] grp, input logic [NUM_SRC-1:0] s);
        case (grp)
            2'd0:    fromSrc = {1'b0, revPeriph(s[6:0])};
            2'd1:    fromSrc = revByte(s[14:7]);
            2'd2:    fromSrc = {4'h0, revNib(s[18:15])};
            default: fromSrc = 8'h00;
        endcase
    endfunction

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    logic [NUM_SRC-1:0] srcPulse;
    logic               winFound;
    logic [4:0]         winIdx;
    vpic_level_e        winLvl;

    assign srcPulse = {revNib(portCPulse), revByte(portAPulse), revPeriph(periphPulse)};

    // Highest level first, lowest index within a level
    always_comb
    begin
        vpic_level_e lv;
        winFound = 1'b0;
        winIdx   = 5'h00;
        winLvl   = VPIC_OFF;
        lv       = VPIC_OFF;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            lv = vpic_level_e'({st.enHigh[i], st.enLow[i]});
            if (st.req[i] && lv != VPIC_OFF && (!winFound || lv >= winLvl))
            begin
                winFound = 1'b1;
                winIdx   = 5'(i);
                winLvl   = lv;
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic [1:0]         grp;
        logic               isReq;
        logic               isEnH;
        logic               isEnL;
        logic [NUM_SRC-1:0] grpMask;
        logic [NUM_SRC-1:0] wval;
        next_st = st;
        grp     = 2'd3;
        isReq   = 1'b0;
        isEnH   = 1'b0;
        isEnL   = 1'b0;
        grpMask = '0;
        wval    = '0;
        case (bus.addr)
            REQ0_ADDR:
            begin
                grp   = 2'd0;
                isReq = 1'b1;
            end
            EN0H_ADDR:
            begin
                grp   = 2'd0;
                isEnH = 1'b1;
            end
            EN0L_ADDR:
            begin
                grp   = 2'd0;
                isEnL = 1'b1;
            end
            REQ1_ADDR:
            begin
                grp   = 2'd1;
                isReq = 1'b1;
            end
            EN1H_ADDR:
            begin
                grp   = 2'd1;
                isEnH = 1'b1;
            end
            EN1L_ADDR:
            begin
                grp   = 2'd1;
                isEnL = 1'b1;
            end
            REQ2_ADDR:
            begin
                grp   = 2'd2;
                isReq = 1'b1;
            end
            EN2H_ADDR:
            begin
                grp   = 2'd2;
                isEnH = 1'b1;
            end
            EN2L_ADDR:
            begin
                grp   = 2'd2;
                isEnL = 1'b1;
            end
            default:   grp = 2'd3;
        endcase
        grpMask = toSrc(grp, 8'hFF);
        wval    = toSrc(grp, bus.wdata);

        // Software writes replace whole groups; reserved bits stay zero
        if (bus.wr && isReq)
            next_st.req = (st.req & ~grpMask) | wval;
        if (bus.wr && isEnH)
            next_st.enHigh = (st.enHigh & ~grpMask) | wval;
        if (bus.wr && isEnL)
            next_st.enLow = (st.enLow & ~grpMask) | wval;

        // Acknowledge clears the named source
        if (ackValid && ackSource < 5'(NUM_SRC))
            next_st.req[ackSource] = 1'b0;

        // Pulses last so they beat a clearing write or ack
        next_st.req = next_st.req | srcPulse;

        // Watchdog latch kept apart from the request registers
        if (watchdogAck)
            next_st.wdogPend = 1'b0;
        if (watchdogPulse && watchdogEnable)
            next_st.wdogPend = 1'b1;

        // Global enable: clears win over sets in the same cycle
        if (coreEv.enableInstr || coreEv.returnInstr)
            next_st.ien = 1'b1;
        if (bus.wr && bus.addr == CTRL_ADDR)
            next_st.ien = bus.wdata[CTRL_IEN_BIT];
        if (coreEv.disableInstr || coreEv.trapInstr || coreEv.illegalTrap
            || ackValid || watchdogAck)
            next_st.ien = 1'b0;

        // Read data valid the cycle after the strobe
        next_st.rdata = 8'h00;
        if (bus.rd)
        begin
            if (isReq)
                next_st.rdata = fromSrc(grp, st.req);
            else if (isEnH)
                next_st.rdata = fromSrc(grp, st.enHigh);
            else if (isEnL)
                next_st.rdata = fromSrc(grp, st.enLow);
            else if (bus.addr == CTRL_ADDR)
                next_st.rdata = {st.ien, 7'h00};
        end

        // Vector presentation; watchdog overrides, no request while disabled
        next_st.irqValid  = 1'b0;
        next_st.irqVector = 16'h0000;
        next_st.irqSource = 5'h00;
        if (next_st.ien && next_st.wdogPend)
        begin
            next_st.irqValid  = 1'b1;
            next_st.irqVector = VEC_WDOG;
            next_st.irqSource = 5'h1F;
        end
        else if (next_st.ien && winFound && !(ackValid && ackSource == winIdx)
                 && next_st.req[winIdx])
        begin
            next_st.irqValid  = 1'b1;
            next_st.irqVector = vecOf(winIdx);
            next_st.irqSource = winIdx;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign rdata     = st.rdata;
    assign irqValid  = st.irqValid;
    assign irqVector = st.irqVector;
    assign irqSource = st.irqSource;

    // ****************************************************************
    // Checks
    // ****************************************************************
    pulse_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
        srcPulse[0] |=> st.req[0])
        else $error("peripheral pulse not latched");

    ack_clears_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ackValid && ackSource == 5'd3 && !srcPulse[3]) |=> !st.req[3])
        else $error("ack did not clear request");

    ack_disables_a: assert property (@(posedge clk) disable iff (!reset_n)
        ackValid |=> !st.ien && !irqValid)
        else $error("enable survived acknowledge");

    disabled_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        !st.ien |-> !irqValid)
        else $error("request forwarded while disabled");

    enable_instr_a: assert property (@(posedge clk) disable iff (!reset_n)
        (coreEv.enableInstr && !coreEv.disableInstr && !coreEv.trapInstr
         && !coreEv.illegalTrap && !ackValid && !watchdogAck && !bus.wr) |=> st.ien)
        else $error("enable instruction ignored");

    write_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (bus.wr && bus.addr == REQ0_ADDR && bus.wdata == 8'h00 && periphPulse == 7'h00)
        |=> st.req[6:0] == 7'h00)
        else $error("write zero left request pending");

    level_order_a: assert property (@(posedge clk) disable iff (!reset_n)
        (irqValid && irqVector != VEC_WDOG)
        |-> (irqSource >= 5'(NUM_SRC) || {st.enHigh[irqSource], st.enLow[irqSource]} != 2'b00))
        else $error("disabled source won arbitration");

    vector_range_a: assert property (@(posedge clk) disable iff (!reset_n)
        (irqValid && irqSource == 5'd0) |-> irqVector == 16'h000A)
        else $error("timer one vector wrong");

    wdog_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st.wdogPend && st.ien && !watchdogAck && !ackValid && !coreEv.disableInstr
         && !coreEv.trapInstr && !coreEv.illegalTrap && !bus.wr)
        |=> irqVector == VEC_WDOG)
        else $error("watchdog did not take precedence");

    write_one_a: assert property (@(posedge clk) disable iff (!reset_n)
        (bus.wr && bus.addr == REQ0_ADDR && bus.wdata[6] && !(ackValid && ackSource == 5'd0))
        |=> st.req[0])
        else $error("write one left request clear");

    pulse_wins_a: assert property (@(posedge clk) disable iff (!reset_n)
        (bus.wr && bus.addr == REQ0_ADDR && bus.wdata == 8'h00 && periphPulse[5])
        |=> st.req[1])
        else $error("pulse lost to clearing write");
endmodule
`default_nettype wire

// ---- sim/vpic_core_model.sv ----
`default_nettype none
module vpic_core_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Test control
    input  wire logic       ackOn,
    input  wire logic [3:0] ackDelay,
    // Controller side
    input  wire logic       irqValid,
    input  wire logic [4:0] irqSource,
    output var  logic       ackValid,
    output var  logic [4:0] ackSource,
    output var  logic       watchdogAck
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] waitCount;

    // Acknowledge the presented source after a programmable wait
    // The source lines toggle when idle so a stale index never matches
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ackValid    <= 1'b0;
            watchdogAck <= 1'b0;
            ackSource   <= 5'h00;
            waitCount   <= 4'h0;
        end
        else
        begin
            ackValid    <= 1'b0;
            watchdogAck <= 1'b0;
            ackSource   <= ~ackSource;
            if (!ackOn || !irqValid || ackValid || watchdogAck)
            begin
                waitCount <= 4'h0;
            end
            else if (waitCount == ackDelay)
            begin
                ackValid    <= (irqSource != 5'h1F);
                watchdogAck <= (irqSource == 5'h1F);
                ackSource   <= irqSource;
                waitCount   <= 4'h0;
            end
            else
            begin
                waitCount <= waitCount + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import vpic_pkg::*;

    typedef struct packed {logic [18:0] pulse; logic [15:0] vec; logic [4:0] src;} vpic_row_s;

    logic clk, reset_n, watchdogPulse, watchdogEnable, ackOn, irqValid;
    logic ackValid, watchdogAck;
    logic [4:0] ackSource, irqSource;
    logic [3:0] ackDelay;
    logic [15:0] irqVector;
    logic [7:0] rdata;
    logic [18:0] pulses;
    vpic_bus_s bus;
    vpic_core_ev_s coreEv;
    vpic_row_s rows [19];
    int errors, samples_checked;

    vpic_controller DUT (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
        .periphPulse(pulses[18:12]), .portAPulse(pulses[11:4]), .portCPulse(pulses[3:0]),
        .watchdogPulse(watchdogPulse), .watchdogEnable(watchdogEnable), .coreEv(coreEv),
        .ackValid(ackValid), .ackSource(ackSource), .watchdogAck(watchdogAck),
        .irqValid(irqValid), .irqVector(irqVector), .irqSource(irqSource));
    vpic_core_model core (.clk(clk), .reset_n(reset_n), .ackOn(ackOn), .ackDelay(ackDelay),
        .irqValid(irqValid), .irqSource(irqSource), .ackValid(ackValid),
        .ackSource(ackSource), .watchdogAck(watchdogAck));

    // ****************************************************************
    // Helpers; wr, rd and pulse return 1 ns after an edge so reads never race
    // ****************************************************************
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 check("rdata", {8'h00, exp}, {8'h00, rdata});
    endtask

    // Sources pulse for exactly one clock
    task automatic pulse(input logic [18:0] p);
        @(posedge clk) pulses <= p;
        @(posedge clk) pulses <= 19'h00000;
        #1;
    endtask

    // Bounded wait for the request line to reach a level
    task automatic waitv(input logic lvl);
        int n;
        n = 0;
        while (irqValid !== lvl && n < 40)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("irqValid", {15'h0000, lvl}, {15'h0000, irqValid});
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Clock at 40 MHz
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog well beyond the expected run of a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        reset_n = 1'b0;
        bus = '0;
        pulses = 19'h00000;
        coreEv = '0;
        watchdogPulse = 1'b0;
        watchdogEnable = 1'b0;
        ackOn = 1'b1;
        ackDelay = 4'h3;
        errors = 0;
        samples_checked = 0;
        for (int i = 0; i < 19; i++)
        begin
            rows[i].pulse = 19'h40000 >> i;
            rows[i].src = 5'(i);
            rows[i].vec = (i < 7) ? VEC_PERIPH + VEC_STEP * 16'(i) :
                          (i < 15) ? VEC_PORTA + VEC_STEP * 16'(i - 7) :
                          VEC_PORTC + VEC_STEP * 16'(i - 15);
        end
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i])
            if (i < 10) rd(12'hFC0 + 12'(i), 8'h00);
        rd(CTRL_ADDR, 8'h00);
        // All sources at the middle level, then one row at a time
        wr(EN0H_ADDR, 8'h7F);
        wr(EN1H_ADDR, 8'hFF);
        wr(EN2H_ADDR, 8'h0F);
        wr(CTRL_ADDR, 8'h80);
        foreach (rows[i])
        begin
            pulse(rows[i].pulse);
            waitv(1'b1);
            check("irqVector", rows[i].vec, irqVector);
            check("irqSource", {11'h000, rows[i].src}, {11'h000, irqSource});
            waitv(1'b0);
            rd(CTRL_ADDR, 8'h00);
            rd((i < 7) ? REQ0_ADDR : (i < 15) ? REQ1_ADDR : REQ2_ADDR, 8'h00);
            @(posedge clk) coreEv.returnInstr <= 1'b1;
            @(posedge clk) coreEv.returnInstr <= 1'b0;
        end
        // Level beats fixed order; same level takes the lowest vector
        ackOn <= 1'b0;
        wr(EN0H_ADDR, 8'h01);
        wr(EN0L_ADDR, 8'h41);
        pulse(19'h41810);
        waitv(1'b1);
        check("irqVector", 16'h0016, irqVector);
        wr(REQ0_ADDR, 8'h40);
        repeat (2) @(posedge clk);
        #1 check("irqVector", 16'h0018, irqVector);
        // Watchdog overrides every programmable source
        @(posedge clk)
        begin
            watchdogEnable <= 1'b1;
            watchdogPulse  <= 1'b1;
        end
        @(posedge clk) watchdogPulse <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("irqVector", VEC_WDOG, irqVector);
        check("irqSource", 16'h001F, {11'h000, irqSource});
        ackOn <= 1'b1;
        waitv(1'b0);
        rd(REQ1_ADDR, 8'h81);
        wr(CTRL_ADDR, 8'h80);
        waitv(1'b1);
        check("irqVector", 16'h0018, irqVector);
        waitv(1'b0);
        rd(REQ1_ADDR, 8'h01);
        // Pulse landing with a write of zero survives
        ackOn <= 1'b0;
        @(posedge clk)
        begin
            bus <= '{REQ0_ADDR, 8'h00, 1'b1, 1'b0};
            pulses <= 19'h20000;
        end
        @(posedge clk)
        begin
            bus.wr <= 1'b0;
            pulses <= 19'h00000;
        end
        rd(REQ0_ADDR, 8'h20);
        wr(REQ0_ADDR, 8'hFF);
        rd(REQ0_ADDR, 8'h7F);
        rd(12'hFC9, 8'h00);
        // Each core event against the opposite starting state
        for (int k = 0; k < 5; k++)
        begin
            wr(CTRL_ADDR, (k == 0 || k == 2) ? 8'h00 : 8'h80);
            @(posedge clk) coreEv <= 5'b10000 >> k;
            @(posedge clk) coreEv <= '0;
            rd(CTRL_ADDR, (k == 0 || k == 2) ? 8'h80 : 8'h00);
            check("irqValid", (k == 0 || k == 2) ? 16'h0001 : 16'h0000, {15'h0000, irqValid});
        end
        // Write of zero with no pulse clears the whole group
        wr(REQ0_ADDR, 8'h00);
        rd(REQ0_ADDR, 8'h00);
        // Reset in mid-run drops the line; REQ1, EN0H and CTRL then read back zero
        wr(CTRL_ADDR, 8'h80);
        waitv(1'b1);
        @(posedge clk) reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("irqValid", 16'h0000, {15'h0000, irqValid});
        @(posedge clk) reset_n <= 1'b1;
        rd(REQ1_ADDR, 8'h00);
        rd(EN0H_ADDR, 8'h00);
        rd(CTRL_ADDR, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
